// file: sim/rtt_host_model.sv
// register-port host model: one-cycle strobes, acknowledge seen one cycle later
`timescale 1ns/1ns
module rtt_host (
    // clock and answer
    input  wire       clk_i,
    input  wire       ack_i,
    // request
    output reg  [7:0] addr_o,
    output reg        wr_o,
    output reg        rd_o,
    output reg  [7:0] wdata_o
);
    initial
    begin
        addr_o  = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end

    task acc(input w, input [7:0] a, input [7:0] d, output ok);
        begin
            @(posedge clk_i);
            #1;
            addr_o  = a;
            wdata_o = d;
            wr_o    = w;
            rd_o    = !w;
            @(posedge clk_i);
            #1;
            wr_o    = 1'b0;
            rd_o    = 1'b0;
            // released lines must not look like the last request
            addr_o  = ~a;
            wdata_o = ~d;
            ok      = ack_i;
        end
    endtask
endmodule // rtt_host

// file: sim/rtt_trim_stamp_monitor.sv
// port checker for the trim and time-stamp block
`timescale 1ns/1ns
module rtt_chk (
    // clock and reset
    input wire       MCLK_I,
    input wire       SRST_I,
    // register port
    input wire       REG_RD_I,
    input wire       REG_WR_I,
    input wire       REG_ACK_O,
    input wire [7:0] REG_RDATA_O,
    // supply and pin
    input wire       VCC_ABOVE_TRIP_I,
    input wire       ON_BACKUP_O,
    input wire       MULTI_FUNCTION_PIN_O,
    input wire       MULTI_FUNCTION_PIN_OE_O
);
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (SRST_I);

    property p_ack;
        (REG_RD_I || REG_WR_I) && !ON_BACKUP_O |=> REG_ACK_O;
    endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge on primary");
    property p_ack_cause;
        REG_ACK_O |-> $past(REG_RD_I || REG_WR_I) && !$past(ON_BACKUP_O);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without strobe");
    property p_no_ack_bkp;
        (REG_RD_I || REG_WR_I) && ON_BACKUP_O |=> !REG_ACK_O;
    endproperty
    a_no_ack_bkp: assert property (p_no_ack_bkp) else $error("bus answered on backup");
    property p_leave;
        VCC_ABOVE_TRIP_I |=> !ON_BACKUP_O;
    endproperty
    a_leave: assert property (p_leave) else $error("backup kept with primary up");
    property p_enter;
        $rose(ON_BACKUP_O) |-> !$past(VCC_ABOVE_TRIP_I);
    endproperty
    a_enter: assert property (p_enter) else $error("backup entered with primary up");
    property p_stay;
        ON_BACKUP_O && !VCC_ABOVE_TRIP_I |=> ON_BACKUP_O;
    endproperty
    a_stay: assert property (p_stay) else $error("backup dropped while primary low");
    property p_pin_zero;
        !MULTI_FUNCTION_PIN_OE_O |-> !MULTI_FUNCTION_PIN_O;
    endproperty
    a_pin_zero: assert property (p_pin_zero) else $error("pin level while undriven");
    property p_rdata;
        !$stable(REG_RDATA_O) |-> REG_ACK_O && $past(REG_RD_I);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved without read");
endmodule // rtt_chk

bind rtt_trim_stamp rtt_chk u_chk (.MCLK_I, .SRST_I, .REG_RD_I, .REG_WR_I, .REG_ACK_O,
    .REG_RDATA_O, .VCC_ABOVE_TRIP_I, .ON_BACKUP_O, .MULTI_FUNCTION_PIN_O,
    .MULTI_FUNCTION_PIN_OE_O);

// file: sim/tb_top.sv
// self-checking bench for the trim and time-stamp block
`timescale 1ns/1ns
module tb_top;
    reg        clk, rst, vcc, osc, ok, rd_q, alm, sqw;
    reg  [7:0] tmin, thour, tdate, tmth, d;
    reg  [7:0] ex [0:7];
    reg  [7:0] q [$];
    wire [7:0] addr, wdata, rdata;
    wire       wr, rd, ack, bkp, trim_tick, pin, pin_oe;
    integer    errors, cmp_count, ticks, k, cal;

    rtt_host u_host (.clk_i(clk), .ack_i(ack), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata));
    rtt_trim_stamp #(.MIN_TICKS(600)) u_dut (.MCLK_I(clk), .SRST_I(rst),
        .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
        .REG_RDATA_O(rdata), .REG_ACK_O(ack), .VCC_ABOVE_TRIP_I(vcc), .ON_BACKUP_O(bkp),
        .OSC_TICK_I(osc), .TIME_MIN_I(tmin), .TIME_HOUR_I(thour), .TIME_DATE_I(tdate),
        .TIME_MTH_I(tmth), .TRIM_TICK_O(trim_tick), .ALARM_OUT_I(alm), .SQW_CLK_I(sqw),
        .MULTI_FUNCTION_PIN_O(pin), .MULTI_FUNCTION_PIN_OE_O(pin_oe));

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp)
            begin
                errors = errors + 1;
                $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task close_out;
        begin
            if (errors == 0 && cmp_count > 0 && q.size() == 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    task wrx(input [7:0] a, input [7:0] v);
        u_host.acc(1'b1, a, v, ok);
    endtask

    task rdx(input [7:0] a, input [7:0] e);
        begin
            q.push_back(e);
            u_host.acc(1'b0, a, 8'h00, ok);
        end
    endtask

    task reset_dut;
        begin
            rst = 1'b1;
            repeat (3) @(posedge clk);
            #1;
            rst = 1'b0;
        end
    endtask

    // new random time on the counters together with the supply step
    task supply(input v, input integer b);
        begin
            tmin  = $urandom;
            thour = $urandom;
            tdate = $urandom;
            tmth  = $urandom;
            vcc   = v;
            ex[b]     = tmin & 8'h7F;
            ex[b + 1] = thour & 8'h7F;
            ex[b + 2] = tdate & 8'h3F;
            ex[b + 3] = tmth;
            repeat (3) @(posedge clk);
            #1;
        end
    endtask

    task trim_case(input [7:0] c, input [7:0] t, input integer n, input integer e);
        begin
            reset_dut;
            wrx(8'h07, c);
            wrx(8'h08, t);
            ticks = 0;
            repeat (n)
            begin
                @(posedge clk);
                #1;
                osc = 1'b1;
                @(posedge clk);
                #1;
                osc = 1'b0;
            end
            repeat (4) @(posedge clk);
            #1;
            chk(ticks[15:0], e[15:0]);
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // result side: each acknowledged read takes the oldest expectation
    always @(posedge clk)
    begin
        rd_q <= rd;
        if (trim_tick === 1'b1)
            ticks = ticks + 1;
        if (ack && rd_q && q.size() > 0)
            chk({8'h00, rdata}, {8'h00, q.pop_front()});
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        errors = errors + 1;
        close_out;
    end

    initial
    begin
        {rst, osc, rd_q, ok, alm, sqw, tmin, thour, tdate, tmth} = 0;
        vcc = 1'b1;
        errors = 0;
        cmp_count = 0;
        ticks = 0;
        k = $urandom(32'h8131);
        reset_dut;
        for (k = 24; k < 32; k = k + 1)
            rdx(k[7:0], 8'h00);
        rdx(8'h03, 8'h00);
        wrx(8'h40, 8'hA5);
        rdx(8'h40, 8'h00);
        d = $urandom;
        wrx(8'h08, d);
        rdx(8'h08, d);
        supply(1'b0, 0);
        chk(bkp, 1'b0);
        rdx(8'h03, 8'h00);
        supply(1'b1, 0);
        wrx(8'h03, 8'h08);
        wrx(8'h07, 8'h80);
        @(posedge clk);
        #1;
        chk({pin_oe, pin}, 2'b11);
        supply(1'b0, 0);
        chk({bkp, pin_oe, pin}, 3'b100);
        u_host.acc(1'b1, 8'h08, ~d, ok);
        chk(ok, 1'b0);
        supply(1'b1, 4);
        for (k = 0; k < 8; k = k + 1)
            rdx(8'h18 + k[7:0], ex[k]);
        rdx(8'h03, 8'h18);
        rdx(8'h08, d);
        // flag still set: a second failure must leave the first record alone
        supply(1'b0, 4);
        supply(1'b1, 4);
        rdx(8'h18, ex[0]);
        wrx(8'h03, 8'h18);
        rdx(8'h03, 8'h18);
        wrx(8'h03, 8'h08);
        for (k = 0; k < 8; k = k + 1)
            rdx(8'h18 + k[7:0], 8'h00);
        supply(1'b0, 0);
        supply(1'b1, 4);
        rdx(8'h18, ex[0]);
        trim_case(8'h44, 8'h00, 266, 266);
        chk({pin_oe, pin}, 2'b11);
        wrx(8'h03, 8'h08);
        supply(1'b0, 4);
        chk({bkp, pin_oe, pin}, 3'b100);
        supply(1'b1, 4);
        wrx(8'h07, 8'h40);
        sqw = 1'b1;
        @(posedge clk);
        #1;
        chk({pin_oe, pin}, 2'b11);
        wrx(8'h07, 8'h10);
        alm = 1'b1;
        supply(1'b0, 4);
        chk({bkp, pin_oe, pin}, 3'b111);
        supply(1'b1, 4);
        trim_case(8'h04, 8'h01, 266, 264);
        // clock lost six ppm over the observation: count from the calibration formula
        cal = 6 * 32768 * 60 / 2000000;
        trim_case(8'h04, {1'b1, cal[6:0]}, 266, 276);
        trim_case(8'h00, 8'h01, 610, 608);
        repeat (4) @(posedge clk);
        close_out;
    end
endmodule // tb_top

// file: verilog/rtt_map.vh
// register map, field positions and timing counts of the trim and time-stamp block
`ifndef RTT_MAP_VH
`define RTT_MAP_VH

`define RTT_ADDR_STATUS     8'h03
`define RTT_ADDR_CONTROL    8'h07
`define RTT_ADDR_TRIM       8'h08
`define RTT_ADDR_DN_MIN     8'h18
`define RTT_ADDR_DN_HOUR    8'h19
`define RTT_ADDR_DN_DATE    8'h1A
`define RTT_ADDR_DN_MTH     8'h1B
`define RTT_ADDR_UP_MIN     8'h1C
`define RTT_ADDR_UP_HOUR    8'h1D
`define RTT_ADDR_UP_DATE    8'h1E
`define RTT_ADDR_UP_MTH     8'h1F

`define RTT_CTL_OUT         7
`define RTT_CTL_SQUARE_WAVE_OUTPUT_ENABLE       6
`define RTT_CTL_SECOND_ALARM_ENABLE      5
`define RTT_CTL_FIRST_ALARM_ENABLE      4
`define RTT_CTL_COARSE_TRIM_SELECT     2
`define RTT_STS_POWER_FAIL_FLAG_BIT 4
`define RTT_STS_BACKUP_INPUT_ENABLE_BIT  3
`define RTT_TRIM_SIGN       7

`define RTT_MASK_MIN        8'h7F
`define RTT_MASK_HOUR       8'h7F
`define RTT_MASK_DATE       8'h3F
`define RTT_MASK_MTH        8'hFF

`define RTT_RST_CONTROL     8'h00
`define RTT_RST_TRIM        8'h00
`define RTT_RST_STAMP       8'h00

`define RTT_OSC_HZ          32768
`define RTT_TRIM_COARSE_HZ  128
`define RTT_SECONDS_PER_MIN 60
`define RTT_SQW_COARSE_HZ   64

`endif

// file: verilog/rtt_trim_stamp.v
// trim engine, supply switchover, output pin control and power-fail time-stamp
`timescale 1ns/1ns
`include "rtt_map.vh"

module rtt_trim_stamp #(
    parameter MIN_TICKS    = `RTT_OSC_HZ * `RTT_SECONDS_PER_MIN,
    parameter COARSE_TICKS = `RTT_OSC_HZ / `RTT_TRIM_COARSE_HZ,
    parameter SQW_HALF     = `RTT_OSC_HZ / (2 * `RTT_SQW_COARSE_HZ)
) (
    // clock and reset
    input  wire       MCLK_I,
    input  wire       SRST_I,
    // register port
    input  wire [7:0] REG_ADDR_I,
    input  wire       REG_WR_I,
    input  wire       REG_RD_I,
    input  wire [7:0] REG_WDATA_I,
    output wire [7:0] REG_RDATA_O,
    output wire       REG_ACK_O,
    // supply sense
    input  wire       VCC_ABOVE_TRIP_I,
    output wire       ON_BACKUP_O,
    // oscillator and running counters
    input  wire       OSC_TICK_I,
    input  wire [7:0] TIME_MIN_I,
    input  wire [7:0] TIME_HOUR_I,
    input  wire [7:0] TIME_DATE_I,
    input  wire [7:0] TIME_MTH_I,
    output wire       TRIM_TICK_O,
    // multi-function pin sources and drive
    input  wire       ALARM_OUT_I,
    input  wire       SQW_CLK_I,
    output wire       MULTI_FUNCTION_PIN_O,
    output wire       MULTI_FUNCTION_PIN_OE_O
);

    reg  [7:0]  control_ff;
    reg  [7:0]  trim_ff;
    reg         power_fail_flag_ff;
    reg         backup_input_enable_ff;
    reg         up_pending_ff;
    reg         on_backup_ff;
    reg  [7:0]  stamp_ff [0:7];
    reg  [20:0] tick_cnt_ff;
    reg  [7:0]  pending_ff;
    reg         add_ff;
    reg         trim_tick_ff;
    reg  [7:0]  sq_cnt_ff;
    reg         sq_ff;
    reg         mfp_ff;
    reg         mfp_oe_ff;
    reg  [7:0]  rdata_ff;
    reg         ack_ff;

    reg  [7:0]  nxt_rdata;
    reg  [7:0]  nxt_pending;
    reg         nxt_trim_tick;
    reg         nxt_mfp;
    reg         nxt_mfp_oe;

    integer     i;

    wire        coarse     = control_ff[`RTT_CTL_COARSE_TRIM_SELECT];
    wire        square_wave_output_enable      = control_ff[`RTT_CTL_SQUARE_WAVE_OUTPUT_ENABLE];
    wire        alm_en     = control_ff[`RTT_CTL_FIRST_ALARM_ENABLE] | control_ff[`RTT_CTL_SECOND_ALARM_ENABLE];
    wire [6:0]  trim_count = trim_ff[6:0];
    wire        nxt_on_backup = ~VCC_ABOVE_TRIP_I & backup_input_enable_ff;
    wire        go_down    = nxt_on_backup & ~on_backup_ff;
    wire        go_up      = ~nxt_on_backup & on_backup_ff;
    wire        bus_live   = ~on_backup_ff;
    wire        wr         = REG_WR_I & bus_live;
    wire        clr_fail   = wr & (REG_ADDR_I == `RTT_ADDR_STATUS)
                             & ~REG_WDATA_I[`RTT_STS_POWER_FAIL_FLAG_BIT];
    wire        log_down   = go_down & (~power_fail_flag_ff | clr_fail);
    wire        log_up     = go_up & up_pending_ff;
    wire        coarse_evt = OSC_TICK_I
                             & (tick_cnt_ff[7:0] == COARSE_TICKS[7:0] - 8'h01);
    wire        min_evt    = OSC_TICK_I
                             & (tick_cnt_ff == MIN_TICKS[20:0] - 21'h00_0001);
    wire        trim_evt   = coarse ? coarse_evt : min_evt;

    // stamp slot index from address: low bits 1..0 field, bit 2 power-up
    function [2:0] slot;
        input [7:0] a;
        begin
            slot = a[2:0];
        end
    endfunction

    function [7:0] field_mask;
        input [1:0] f;
        begin
            case (f)
                2'd0:    field_mask = `RTT_MASK_MIN;
                2'd1:    field_mask = `RTT_MASK_HOUR;
                2'd2:    field_mask = `RTT_MASK_DATE;
                default: field_mask = `RTT_MASK_MTH;
            endcase
        end
    endfunction

    wire [7:0]  stamp_base = `RTT_ADDR_DN_MIN;
    wire        stamp_hit  = (REG_ADDR_I[7:3] == stamp_base[7:3]);

    // supply state and power-fail record keeping
    always @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            on_backup_ff  <= 1'b0;
            power_fail_flag_ff    <= 1'b0;
            backup_input_enable_ff     <= 1'b0;
            up_pending_ff <= 1'b0;
            for (i = 0; i < 8; i = i + 1)
                stamp_ff[i] <= `RTT_RST_STAMP;
        end
        else
        begin
            on_backup_ff <= nxt_on_backup;
            if (wr && REG_ADDR_I == `RTT_ADDR_STATUS)
                backup_input_enable_ff <= REG_WDATA_I[`RTT_STS_BACKUP_INPUT_ENABLE_BIT];
            if (wr && stamp_hit)
                stamp_ff[slot(REG_ADDR_I)] <= REG_WDATA_I & field_mask(REG_ADDR_I[1:0]);
            if (clr_fail)
            begin
                power_fail_flag_ff    <= 1'b0;
                up_pending_ff <= 1'b0;
                for (i = 0; i < 8; i = i + 1)
                    stamp_ff[i] <= `RTT_RST_STAMP;
            end
            // capture comes last so a failure beats a clear in the same cycle
            if (go_down)
                power_fail_flag_ff    <= 1'b1;
            if (log_down)
            begin
                up_pending_ff <= 1'b1;
                stamp_ff[0]   <= TIME_MIN_I  & `RTT_MASK_MIN;
                stamp_ff[1]   <= TIME_HOUR_I & `RTT_MASK_HOUR;
                stamp_ff[2]   <= TIME_DATE_I & `RTT_MASK_DATE;
                stamp_ff[3]   <= TIME_MTH_I  & `RTT_MASK_MTH;
            end
            if (log_up)
            begin
                up_pending_ff <= 1'b0;
                stamp_ff[4]   <= TIME_MIN_I  & `RTT_MASK_MIN;
                stamp_ff[5]   <= TIME_HOUR_I & `RTT_MASK_HOUR;
                stamp_ff[6]   <= TIME_DATE_I & `RTT_MASK_DATE;
                stamp_ff[7]   <= TIME_MTH_I  & `RTT_MASK_MTH;
            end
        end
    end

    // control and trim registers, retained across backup operation
    always @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            control_ff <= `RTT_RST_CONTROL;
            trim_ff    <= `RTT_RST_TRIM;
        end
        else
        begin
            if (wr && REG_ADDR_I == `RTT_ADDR_CONTROL)
                control_ff <= REG_WDATA_I;
            if (wr && REG_ADDR_I == `RTT_ADDR_TRIM)
                trim_ff <= REG_WDATA_I;
        end
    end

    // read path; silent while on backup
    always @*
    begin
        nxt_rdata = 8'h00;
        if (stamp_hit)
            nxt_rdata = stamp_ff[slot(REG_ADDR_I)];
        else if (REG_ADDR_I == `RTT_ADDR_CONTROL)
            nxt_rdata = control_ff;
        else if (REG_ADDR_I == `RTT_ADDR_TRIM)
            nxt_rdata = trim_ff;
        else if (REG_ADDR_I == `RTT_ADDR_STATUS)
        begin
            nxt_rdata[`RTT_STS_POWER_FAIL_FLAG_BIT] = power_fail_flag_ff;
            nxt_rdata[`RTT_STS_BACKUP_INPUT_ENABLE_BIT]  = backup_input_enable_ff;
        end
    end

    always @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            rdata_ff <= 8'h00;
            ack_ff   <= 1'b0;
        end
        else
        begin
            ack_ff <= (REG_RD_I | REG_WR_I) & bus_live;
            if (REG_RD_I && bus_live)
                rdata_ff <= nxt_rdata;
        end
    end

    // trim: swallow oscillator ticks to slow down, insert extra ones to speed up;
    // inserted ticks land on idle system-clock cycles between oscillator ticks
    always @*
    begin
        nxt_pending   = pending_ff;
        nxt_trim_tick = OSC_TICK_I;
        if (pending_ff != 8'h00)
        begin
            if (!add_ff && OSC_TICK_I)
            begin
                nxt_trim_tick = 1'b0;
                nxt_pending   = pending_ff - 8'h01;
            end
            else if (add_ff && !OSC_TICK_I)
            begin
                nxt_trim_tick = 1'b1;
                nxt_pending   = pending_ff - 8'h01;
            end
        end
        if (trim_evt && trim_count != 7'h00)
            nxt_pending = {trim_count, 1'b0};
    end

    always @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            tick_cnt_ff  <= 21'h00_0000;
            pending_ff   <= 8'h00;
            add_ff       <= 1'b0;
            trim_tick_ff <= 1'b0;
        end
        else
        begin
            if (OSC_TICK_I)
                tick_cnt_ff <= min_evt ? 21'h00_0000 : tick_cnt_ff + 21'h00_0001;
            pending_ff   <= nxt_pending;
            trim_tick_ff <= nxt_trim_tick;
            if (trim_evt)
                add_ff <= trim_ff[`RTT_TRIM_SIGN];
        end
    end

    // 64 Hz coarse-trim square wave built from the trimmed tick stream
    always @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            sq_cnt_ff <= 8'h00;
            sq_ff     <= 1'b0;
        end
        else if (trim_tick_ff)
        begin
            if (sq_cnt_ff == SQW_HALF[7:0] - 8'h01)
            begin
                sq_cnt_ff <= 8'h00;
                sq_ff     <= ~sq_ff;
            end
            else
                sq_cnt_ff <= sq_cnt_ff + 8'h01;
        end
    end

    // pin mux: alarm survives backup, clock and general output do not
    always @*
    begin
        nxt_mfp    = 1'b0;
        nxt_mfp_oe = 1'b0;
        if (square_wave_output_enable)
        begin
            nxt_mfp    = coarse ? sq_ff : SQW_CLK_I;
            nxt_mfp_oe = ~nxt_on_backup;
        end
        else if (alm_en)
        begin
            nxt_mfp    = ALARM_OUT_I;
            nxt_mfp_oe = 1'b1;
        end
        else
        begin
            nxt_mfp    = control_ff[`RTT_CTL_OUT];
            nxt_mfp_oe = ~nxt_on_backup;
        end
        if (!nxt_mfp_oe)
            nxt_mfp = 1'b0;
    end

    always @(posedge MCLK_I)
    begin
        if (SRST_I)
        begin
            mfp_ff    <= 1'b0;
            mfp_oe_ff <= 1'b0;
        end
        else
        begin
            mfp_ff    <= nxt_mfp;
            mfp_oe_ff <= nxt_mfp_oe;
        end
    end

    assign REG_RDATA_O             = rdata_ff;
    assign REG_ACK_O               = ack_ff;
    assign ON_BACKUP_O             = on_backup_ff;
    assign TRIM_TICK_O             = trim_tick_ff;
    assign MULTI_FUNCTION_PIN_O    = mfp_ff;
    assign MULTI_FUNCTION_PIN_OE_O = mfp_oe_ff;

endmodule // rtt_trim_stamp
